// *** osc_pkg.sv ***
// constants, field layouts and types shared by the on-chip sram controller
package osc_pkg;

  // ==========================================================================
  // widths and array geometry
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LINE_W = 64;
  localparam int unsigned SRAM_BYTES = 4096;
  localparam int unsigned ROW_N = 512;
  localparam int unsigned ROW_AW = 9;
  localparam int unsigned LANE_N = 8;
  localparam int unsigned REG_AW = 10;
  localparam int unsigned CMP_W = 6;

  // ==========================================================================
  // register offsets on the control port
  localparam logic [9:0] OFS_INSTR_WINDOW_COMPARE = 10'h018;
  localparam logic [9:0] OFS_INSTR_SIDE_CONTROL = 10'h019;
  localparam logic [9:0] OFS_DATA_WINDOW_COMPARE = 10'h01A;
  localparam logic [9:0] OFS_DATA_SIDE_CONTROL = 10'h01B;

  // ==========================================================================
  // field positions, little-endian bit numbers (bit 31 is the msb)
  localparam int unsigned CMP_MSB = 31;
  localparam int unsigned CMP_LSB = 26;
  localparam int unsigned CTL_ENABLE_BIT = 31;
  localparam int unsigned CTL_TWO_CYCLE_BIT = 30;
  localparam int unsigned CTL_BUSY_BIT = 29;

  // ==========================================================================
  // address fields used inside the window
  localparam int unsigned ROW_MSB = 11;
  localparam int unsigned ROW_LSB = 3;
  localparam int unsigned HALF_BIT = 2;
  localparam int unsigned BYP_MSB = 13;
  localparam int unsigned BYP_LSB = 2;

  // ==========================================================================
  // reset values
  localparam logic [5:0] RST_COMPARE = 6'h00;
  localparam logic RST_INSTR_ENABLE = 1'h0;
  localparam logic RST_INSTR_TWO_CYCLE = 1'h1;
  localparam logic RST_DATA_ENABLE = 1'h0;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // ==========================================================================
  // instruction fetch sequencer states
  typedef enum logic [0:0] {
    OSC_FETCH_IDLE,
    OSC_FETCH_SETUP
  } osc_fetch_state_t;

endpackage

// *** osc_sram_array.sv ***
// single-port 4KB sram array, 64-bit rows with byte-lane write enables
`timescale 1ns/10ps
module osc_sram_array (
  input wire logic i_core_clk,
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [osc_pkg::ROW_AW-1:0] i_row,
  input wire logic [osc_pkg::LANE_N-1:0] i_be,
  input wire logic [osc_pkg::LINE_W-1:0] i_wdata,
  output logic [osc_pkg::LINE_W-1:0] o_rdata
);

  // ==========================================================================
  // storage, one array per byte lane so each lane writes on its own
  logic [osc_pkg::LINE_W-1:0] rdata_q;

  genvar lane;
  generate
    for (lane = 0; lane < osc_pkg::LANE_N; lane++) begin : g_lane
      logic [7:0] mem [osc_pkg::ROW_N];
      // contents are never reset: software must load them before use
      always_ff @(posedge i_core_clk) begin
        if (i_en && i_we && i_be[lane]) begin
          mem[i_row] <= i_wdata[lane*8 +: 8];
        end
        if (i_en && !i_we) begin
          rdata_q[lane*8 +: 8] <= mem[i_row];
        end
      end
    end
  endgenerate

  assign o_rdata = rdata_q;

endmodule

// *** osc_ctrl.sv ***
// on-chip sram controller: window decode, port arbitration, store queue, control registers
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps

// Overview of operation
// - one shared single-port 4KB sram array
// - priority loads, then stores, then fetches
// - granted load reads array in one cycle
// - store waits while loads hold the port
// - fetch two cycles after reset, else one
// - six-bit compare per side, 64MB windows
// - windows placed anywhere on 64MB boundaries
// - data byte address from low twelve bits
// - fetch ignores byte bits, returns two words
// - whole window aliases onto the 4KB array
// - untranslated 32-bit addresses, bits 31:26 decoded
// - no byte swapping; instructions stored big-endian
// - data returned straight to core, uncached
// - disabling fetch may cut inflight fetches
// - back-to-back loads starve fetches, no fairness
// - fetch answered only when enabled and matching
// - reset: fetch disabled, two-cycle mode set
// - queued store bypassed on bits 13:2 match
module osc_ctrl (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // control register port
  input wire logic [osc_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [osc_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [osc_pkg::DATA_W-1:0] o_reg_rdata,
  // data side load/store port
  input wire logic i_d_req,
  input wire logic i_d_we,
  input wire logic [osc_pkg::ADDR_W-1:0] i_d_addr,
  input wire logic [3:0] i_d_be,
  input wire logic [osc_pkg::DATA_W-1:0] i_d_wdata,
  output logic o_d_hit,
  output logic o_d_rvalid,
  output logic [osc_pkg::DATA_W-1:0] o_d_rdata,
  // instruction fetch port
  input wire logic i_i_req,
  input wire logic [osc_pkg::ADDR_W-1:0] i_i_addr,
  output logic o_i_hit,
  output logic o_i_gnt,
  output logic o_i_rvalid,
  output logic [osc_pkg::LINE_W-1:0] o_i_rdata
);

  // ==========================================================================
  // window decode helper, shared by both sides
  // bits 31:26 of the 32-bit effective address are compared, no translation here
  function automatic logic win_hit(input logic [osc_pkg::ADDR_W-1:0] addr,
                                   input logic [osc_pkg::CMP_W-1:0] cmp,
                                   input logic en);
    win_hit = en && (addr[osc_pkg::CMP_MSB:osc_pkg::CMP_LSB] == cmp);
  endfunction

  // ==========================================================================
  // control state
  logic [osc_pkg::CMP_W-1:0] instr_window_compare_q;
  logic [osc_pkg::CMP_W-1:0] data_window_compare_q;
  logic instr_side_enable_q;
  logic instr_two_cycle_mode_q;
  logic data_side_enable_q;
  logic [osc_pkg::DATA_W-1:0] reg_rdata_q;

  // store queue: one entry, holds a store until a load-free cycle
  logic sq_valid_q;
  logic [osc_pkg::ADDR_W-1:0] sq_addr_q;
  logic [3:0] sq_be_q;
  logic [osc_pkg::DATA_W-1:0] sq_data_q;

  // load return pipeline
  logic d_rvalid_q;
  logic d_half_q;
  logic byp_q;
  logic [3:0] byp_be_q;
  logic [osc_pkg::DATA_W-1:0] byp_data_q;

  // fetch sequencer
  osc_pkg::osc_fetch_state_t fetch_state_q;
  osc_pkg::osc_fetch_state_t fetch_state_d;
  logic i_rvalid_q;

  // ==========================================================================
  // request decode
  wire d_claim = i_d_req && win_hit(i_d_addr, data_window_compare_q, data_side_enable_q);
  wire i_claim = i_i_req && win_hit(i_i_addr, instr_window_compare_q, instr_side_enable_q);
  wire load_go = d_claim && !i_d_we;
  wire store_in = d_claim && i_d_we;
  // queued store uses the port only when no load claims it
  wire drain_go = sq_valid_q && !load_go;
  // fetch waits for a cycle with no load and no queued store, no fairness
  wire port_free = !load_go && !sq_valid_q;
  logic fetch_ready;
  wire fetch_go = fetch_ready && port_free;

  assign o_d_hit = d_claim;
  assign o_i_hit = i_claim;
  assign o_i_gnt = fetch_go;

  // ==========================================================================
  // fetch timing: two-cycle mode inserts a setup cycle before the array read
  always_comb begin
    fetch_state_d = fetch_state_q;
    fetch_ready = 1'h0;
    case (fetch_state_q)
      osc_pkg::OSC_FETCH_IDLE: begin
        if (i_claim && !instr_two_cycle_mode_q) begin
          fetch_ready = 1'h1;
        end else if (i_claim) begin
          fetch_state_d = osc_pkg::OSC_FETCH_SETUP;
        end
      end
      osc_pkg::OSC_FETCH_SETUP: begin
        // a dropped request or a cleared enable cuts the fetch off
        fetch_ready = i_claim;
        // port_free, not fetch_go, so this process never reads its own output
        if (!i_claim || port_free) begin
          fetch_state_d = osc_pkg::OSC_FETCH_IDLE;
        end
      end
      default: begin
        fetch_state_d = osc_pkg::OSC_FETCH_IDLE;
      end
    endcase
  end

  // sequencer register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      fetch_state_q <= osc_pkg::OSC_FETCH_IDLE;
    end else begin
      fetch_state_q <= fetch_state_d;
    end
  end

  // ==========================================================================
  // sram port select: load, then queued store, then fetch
  // only bits 11:0 reach the array, so every window aliases the 4KB
  wire [osc_pkg::ROW_AW-1:0] d_row = i_d_addr[osc_pkg::ROW_MSB:osc_pkg::ROW_LSB];
  wire [osc_pkg::ROW_AW-1:0] sq_row = sq_addr_q[osc_pkg::ROW_MSB:osc_pkg::ROW_LSB];
  // fetch drops bits 2:0 and returns the whole doubleword
  wire [osc_pkg::ROW_AW-1:0] i_row = i_i_addr[osc_pkg::ROW_MSB:osc_pkg::ROW_LSB];
  wire sq_half = sq_addr_q[osc_pkg::HALF_BIT];

  wire arr_en = load_go || drain_go || fetch_go;
  wire arr_we = drain_go;
  wire [osc_pkg::ROW_AW-1:0] arr_row = load_go ? d_row : (drain_go ? sq_row : i_row);
  // byte lanes kept as written: no swapping on either side
  wire [osc_pkg::LANE_N-1:0] arr_be = sq_half ? {sq_be_q, 4'h0} : {4'h0, sq_be_q};
  wire [osc_pkg::LINE_W-1:0] arr_wdata = {sq_data_q, sq_data_q};
  logic [osc_pkg::LINE_W-1:0] arr_rdata;

  // one port shared by instruction and data sides
  osc_sram_array u_array (
    .i_core_clk(i_core_clk),
    .i_en(arr_en),
    .i_we(arr_we),
    .i_row(arr_row),
    .i_be(arr_be),
    .i_wdata(arr_wdata),
    .o_rdata(arr_rdata)
  );

  // ==========================================================================
  // store queue: a new store always enters, the older one drains the same
  // cycle because a store cycle carries no load
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sq_valid_q <= 1'h0;
    end else if (store_in) begin
      sq_valid_q <= 1'h1;
    end else if (drain_go) begin
      sq_valid_q <= 1'h0;
    end
  end

  // queue payload, no reset needed behind the valid bit
  always_ff @(posedge i_core_clk) begin
    if (store_in) begin
      sq_addr_q <= i_d_addr;
      sq_be_q <= i_d_be;
      sq_data_q <= i_d_wdata;
    end
  end

  // ==========================================================================
  // store bypass: compare on 16KB word address, so 4KB aliases that
  // differ in bits 13:12 read stale array data
  wire byp_hit = sq_valid_q &&
                 (sq_addr_q[osc_pkg::BYP_MSB:osc_pkg::BYP_LSB] == i_d_addr[osc_pkg::BYP_MSB:osc_pkg::BYP_LSB]);

  // load return flags
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      d_rvalid_q <= 1'h0;
      byp_q <= 1'h0;
    end else begin
      d_rvalid_q <= load_go;
      byp_q <= load_go && byp_hit;
    end
  end

  // load return payload captured beside the array read
  always_ff @(posedge i_core_clk) begin
    if (load_go) begin
      d_half_q <= i_d_addr[osc_pkg::HALF_BIT];
      byp_be_q <= sq_be_q;
      byp_data_q <= sq_data_q;
    end
  end

  // ==========================================================================
  // load data: array word, queued bytes override where they were stored
  wire [osc_pkg::DATA_W-1:0] d_word = d_half_q ? arr_rdata[63:32] : arr_rdata[31:0];

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_byp
      assign o_d_rdata[b*8 +: 8] = (byp_q && byp_be_q[b]) ? byp_data_q[b*8 +: 8] : d_word[b*8 +: 8];
    end
  endgenerate

  // results go straight to the core, never through a cache
  assign o_d_rvalid = d_rvalid_q;
  assign o_i_rdata = arr_rdata;
  assign o_i_rvalid = i_rvalid_q;

  // fetch return flag
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      i_rvalid_q <= 1'h0;
    end else begin
      i_rvalid_q <= fetch_go;
    end
  end

  // ==========================================================================
  // control register decode
  wire sel_icmp = (i_reg_addr == osc_pkg::OFS_INSTR_WINDOW_COMPARE);
  wire sel_ictl = (i_reg_addr == osc_pkg::OFS_INSTR_SIDE_CONTROL);
  wire sel_dcmp = (i_reg_addr == osc_pkg::OFS_DATA_WINDOW_COMPARE);
  wire sel_dctl = (i_reg_addr == osc_pkg::OFS_DATA_SIDE_CONTROL);

  // read views, reserved bits read as zero
  wire [osc_pkg::DATA_W-1:0] icmp_view = {instr_window_compare_q, 26'h0000000};
  wire [osc_pkg::DATA_W-1:0] dcmp_view = {data_window_compare_q, 26'h0000000};
  wire [osc_pkg::DATA_W-1:0] ictl_view = {instr_side_enable_q, instr_two_cycle_mode_q,
                                          (fetch_state_q == osc_pkg::OSC_FETCH_SETUP), 29'h00000000};
  wire [osc_pkg::DATA_W-1:0] dctl_view = {data_side_enable_q, 1'h0, sq_valid_q, 29'h00000000};

  wire [osc_pkg::DATA_W-1:0] reg_view = sel_icmp ? icmp_view :
                                        sel_ictl ? ictl_view :
                                        sel_dcmp ? dcmp_view :
                                        sel_dctl ? dctl_view : osc_pkg::RST_WORD;

  // ==========================================================================
  // control register writes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      instr_window_compare_q <= osc_pkg::RST_COMPARE;
      data_window_compare_q <= osc_pkg::RST_COMPARE;
      instr_side_enable_q <= osc_pkg::RST_INSTR_ENABLE;
      instr_two_cycle_mode_q <= osc_pkg::RST_INSTR_TWO_CYCLE;
      data_side_enable_q <= osc_pkg::RST_DATA_ENABLE;
    end else if (i_reg_wr) begin
      if (sel_icmp) begin
        instr_window_compare_q <= i_reg_wdata[osc_pkg::CMP_MSB:osc_pkg::CMP_LSB];
      end
      if (sel_dcmp) begin
        data_window_compare_q <= i_reg_wdata[osc_pkg::CMP_MSB:osc_pkg::CMP_LSB];
      end
      if (sel_ictl) begin
        instr_side_enable_q <= i_reg_wdata[osc_pkg::CTL_ENABLE_BIT];
        instr_two_cycle_mode_q <= i_reg_wdata[osc_pkg::CTL_TWO_CYCLE_BIT];
      end
      if (sel_dctl) begin
        // two-cycle mode has no data-side counterpart
        data_side_enable_q <= i_reg_wdata[osc_pkg::CTL_ENABLE_BIT];
      end
    end
  end

  // ==========================================================================
  // register read data, valid the cycle after the read strobe only
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      reg_rdata_q <= osc_pkg::RST_WORD;
    end else if (i_reg_rd) begin
      reg_rdata_q <= reg_view;
    end else begin
      reg_rdata_q <= osc_pkg::RST_WORD;
    end
  end

  assign o_reg_rdata = reg_rdata_q;

endmodule

// *** osc_ctrl_asserts.sv ***
// port checks for the on-chip sram controller
`timescale 1ns/10ps
module osc_ctrl_asserts (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [9:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_d_req,
  input wire logic i_d_we,
  input wire logic [31:0] i_d_addr,
  input wire logic o_d_hit,
  input wire logic o_d_rvalid,
  input wire logic i_i_req,
  input wire logic [31:0] i_i_addr,
  input wire logic o_i_hit,
  input wire logic o_i_gnt,
  input wire logic o_i_rvalid
);
  // ==========
  // shadow of the window fields, so decode is judged against what software wrote
  logic [5:0] icmp_q;
  logic [5:0] dcmp_q;
  logic [1:0] ictl_q;
  logic den_q;
  wire wr_ic = i_reg_wr && i_reg_addr == osc_pkg::OFS_INSTR_WINDOW_COMPARE;
  wire wr_il = i_reg_wr && i_reg_addr == osc_pkg::OFS_INSTR_SIDE_CONTROL;
  wire wr_dc = i_reg_wr && i_reg_addr == osc_pkg::OFS_DATA_WINDOW_COMPARE;
  wire wr_dl = i_reg_wr && i_reg_addr == osc_pkg::OFS_DATA_SIDE_CONTROL;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      icmp_q <= osc_pkg::RST_COMPARE;
      dcmp_q <= osc_pkg::RST_COMPARE;
      ictl_q <= {osc_pkg::RST_INSTR_ENABLE, osc_pkg::RST_INSTR_TWO_CYCLE};
      den_q <= osc_pkg::RST_DATA_ENABLE;
    end else begin
      icmp_q <= wr_ic ? i_reg_wdata[31:26] : icmp_q;
      ictl_q <= wr_il ? i_reg_wdata[31:30] : ictl_q;
      dcmp_q <= wr_dc ? i_reg_wdata[31:26] : dcmp_q;
      den_q <= wr_dl ? i_reg_wdata[31] : den_q;
    end
  end

  // ==========
  // assertions, all in the core clock domain
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_load;
    i_d_req && !i_d_we && o_d_hit;
  endsequence
  sequence s_fetch_done;
    ##1 o_i_rvalid;
  endsequence
  d_decode_a: assert property (i_d_req |-> o_d_hit == (den_q && i_d_addr[31:26] == dcmp_q))
    else $error("data claim wrong");
  i_decode_a: assert property (i_i_req |-> o_i_hit == (ictl_q[1] && i_i_addr[31:26] == icmp_q))
    else $error("fetch claim wrong");
  load_answer_a: assert property (s_load |=> o_d_rvalid)
    else $error("load not answered");
  load_cause_a: assert property (o_d_rvalid |-> $past(i_d_req && !i_d_we && o_d_hit))
    else $error("stray load answer");
  load_first_a: assert property (s_load |-> !o_i_gnt)
    else $error("fetch beat a load");
  two_cycle_a: assert property (ictl_q[0] && $rose(i_i_req) |-> !o_i_gnt)
    else $error("fetch too early");
  fetch_answer_a: assert property (o_i_gnt |-> s_fetch_done)
    else $error("fetch not answered");
  gnt_cause_a: assert property (o_i_gnt |-> i_i_req && o_i_hit)
    else $error("grant without claim");
  fetch_cause_a: assert property (o_i_rvalid |-> $past(o_i_gnt))
    else $error("stray fetch answer");
endmodule

bind osc_ctrl osc_ctrl_asserts u_asserts (.i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_d_req,
  .i_d_we, .i_d_addr, .o_d_hit, .o_d_rvalid, .i_i_req, .i_i_addr, .o_i_hit, .o_i_gnt, .o_i_rvalid);

// *** osc_core_fetch.sv ***
// behavioural core fetch port: holds a request until granted or gives up
`timescale 1ns/10ps
module osc_core_fetch (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [31:0] i_addr,
  input wire logic i_gnt,
  output logic o_req,
  output logic [31:0] o_addr,
  output logic [7:0] o_waited
);
  // ==========
  // a refused fetch is dropped after 32 cycles, else the core would hang
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_req <= 1'b0;
      o_addr <= 32'h0;
      o_waited <= 8'h00;
    end else if (i_go) begin
      o_req <= 1'b1;
      o_addr <= i_addr;
      o_waited <= 8'h00;
    end else if (o_req && !i_gnt && o_waited != 8'h1F) begin
      o_waited <= o_waited + 8'h01;
    end else begin
      o_req <= 1'b0;
      o_addr <= ~o_addr; // released lines never keep the old address
    end
  end
endmodule

// *** osc_ctrl_tb.sv ***
// self-checking bench for the on-chip sram controller
`timescale 1ns/10ps
module osc_ctrl_tb;
  localparam logic [31:0] DBASE = 32'h14000000;
  localparam logic [31:0] IBASE = 32'hA8000000;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_d_req = 1'b0, i_d_we = 1'b0, go = 1'b0, rd_pend = 1'b0;
  logic [9:0] i_reg_addr = 10'h000;
  logic [3:0] i_d_be = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0, i_d_addr = 32'h0, i_d_wdata = 32'h0, go_addr = 32'h0, w;
  logic [31:0] o_reg_rdata, o_d_rdata, i_i_addr;
  logic o_d_hit, o_d_rvalid, o_i_hit, o_i_gnt, o_i_rvalid, i_i_req;
  logic [63:0] o_i_rdata;
  logic [7:0] waited;
  logic [31:0] wmem [1024];
  logic [31:0] dq [$];
  logic [31:0] rq [$];
  logic [63:0] iq [$];
  int num_errors = 0;
  int n_compared = 0;

  osc_ctrl DUT (.i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_d_req,
    .i_d_we, .i_d_addr, .i_d_be, .i_d_wdata, .o_d_hit, .o_d_rvalid, .o_d_rdata, .i_i_req, .i_i_addr, .o_i_hit,
    .o_i_gnt, .o_i_rvalid, .o_i_rdata);
  osc_core_fetch core (.i_core_clk, .i_rst(i_sys_rst), .i_go(go), .i_addr(go_addr), .i_gnt(o_i_gnt),
    .o_req(i_i_req), .o_addr(i_i_addr), .o_waited(waited));

  // ==========
  // 20 MHz core clock
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========
  // bus tasks; a read passes its expected value in d
  task automatic reg_op(input logic wr, input logic [9:0] a, input logic [31:0] d);
    i_reg_wr <= wr;
    i_reg_rd <= !wr;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    if (!wr) rq.push_back(d);
    @(posedge i_core_clk);
  endtask
  task automatic reg_idle();
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic d_op(input logic we, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be, input logic ans);
    i_d_req <= 1'b1;
    i_d_we <= we;
    i_d_addr <= a;
    i_d_wdata <= d;
    i_d_be <= be;
    for (int i = 0; i < 4; i++) begin
      if (we && be[i]) wmem[a[11:2]][8*i+:8] = d[8*i+:8];
    end
    if (ans) dq.push_back(d);
    @(posedge i_core_clk);
  endtask
  task automatic d_idle();
    i_d_req <= 1'b0;
    i_d_addr <= ~i_d_addr;
    @(posedge i_core_clk);
  endtask
  // fetch with optional back-to-back loads competing for the port
  task automatic fetch(input logic [31:0] a, input logic [7:0] lat, input logic ans, input int loads);
    go <= 1'b1;
    go_addr <= a;
    if (ans) iq.push_back({wmem[{a[11:3], 1'b1}], wmem[{a[11:3], 1'b0}]});
    @(posedge i_core_clk);
    go <= 1'b0;
    repeat (loads) d_op(1'b0, DBASE + 32'h10, wmem[4], 4'hF, 1'b1);
    if (loads > 0) d_idle();
    @(negedge i_core_clk);
    while (i_i_req === 1'b1) @(negedge i_core_clk);
    check(waited, lat);
    @(posedge i_core_clk);
  endtask

  // ==========
  // answer monitor: each answer takes the oldest note of its kind
  always @(posedge i_core_clk) rd_pend <= i_reg_rd;
  always @(negedge i_core_clk) begin
    // an answer with no note pending is a mismatch, never an unknown compare
    if (o_d_rvalid === 1'b1 && dq.size() == 0) check(1'b1, 1'b0);
    else if (o_d_rvalid === 1'b1) check(o_d_rdata, dq.pop_front());
    if (o_i_rvalid === 1'b1 && iq.size() == 0) check(1'b1, 1'b0);
    else if (o_i_rvalid === 1'b1) check(o_i_rdata, iq.pop_front());
    if (rd_pend && rq.size() == 0) check(1'b1, 1'b0);
    else if (rd_pend) check(o_reg_rdata, rq.pop_front());
  end

  // ==========
  // main sequence
  initial begin
    void'($urandom(10));
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    reg_op(1'b0, 10'h018, 32'h0);
    reg_op(1'b0, 10'h019, 32'h40000000);
    reg_op(1'b1, 10'h3FF, 32'hFFFFFFFF);
    reg_op(1'b0, 10'h3FF, 32'h0);
    reg_op(1'b1, 10'h01A, DBASE);
    reg_op(1'b1, 10'h01B, 32'h80000000);
    reg_op(1'b1, 10'h018, IBASE);
    reg_op(1'b1, 10'h019, 32'hC0000000);
    reg_op(1'b0, 10'h01A, DBASE);
    reg_op(1'b0, 10'h01B, 32'h80000000);
    reg_op(1'b0, 10'h019, 32'hC0000000);
    reg_idle();
    for (int i = 0; i < 16; i++) d_op(1'b1, DBASE + ($urandom & 32'h03FFF000) + 4 * i, $urandom, 4'hF, 1'b0);
    d_idle();
    for (int i = 0; i < 16; i++) d_op(1'b0, DBASE + ($urandom & 32'h03FFF000) + 4 * i, wmem[i], 4'hF, 1'b1);
    d_op(1'b1, DBASE + 32'h8, $urandom, 4'($urandom), 1'b0);
    d_idle();
    d_op(1'b0, DBASE + 32'h8, wmem[2], 4'hF, 1'b1);
    w = wmem[5];
    d_op(1'b1, DBASE + 32'h14, $urandom, 4'hF, 1'b0);
    d_op(1'b0, DBASE + 32'h1014, w, 4'hF, 1'b1);
    d_op(1'b0, DBASE + 32'h4014, wmem[5], 4'hF, 1'b1);
    d_idle();
    d_op(1'b0, DBASE + 32'h1014, wmem[5], 4'hF, 1'b1);
    d_op(1'b0, 32'h18000014, 32'h0, 4'hF, 1'b0);
    d_idle();
    // words stored earlier by the data side are now fetched as instructions
    fetch(IBASE + ($urandom & 32'h03FFF000) + 32'h13, 8'h01, 1'b1, 0);
    reg_op(1'b1, 10'h019, 32'h80000000);
    reg_idle();
    fetch(IBASE + 32'h0C, 8'h00, 1'b1, 0);
    fetch(IBASE + 32'h20, 8'h05, 1'b1, 5);
    fetch(32'hAC000020, 8'h1F, 1'b0, 0);
    reg_op(1'b1, 10'h019, 32'h0);
    reg_op(1'b1, 10'h01B, 32'h0);
    reg_idle();
    fetch(IBASE, 8'h1F, 1'b0, 0);
    d_op(1'b0, DBASE, 32'h0, 4'hF, 1'b0);
    d_idle();
    repeat (3) @(posedge i_core_clk);
    check(dq.size() + iq.size() + rq.size(), 0);
    conclude();
  end

  // ==========
  // watchdog, far beyond the roughly 160 cycles the run needs
  initial begin
    repeat (5000) @(posedge i_core_clk);
    num_errors++;
    conclude();
  end
endmodule
